// file: shared/frame_composer_regs.vh
`ifndef FRAME_COMPOSER_REGS_VH
`define FRAME_COMPOSER_REGS_VH

// Register map of the output frame control register.
`define OFC_OFFSET 8'h10
`define OFC_WRITE_MASK 32'h0000_7d0f
`define OFC_RESET 32'h0000_0000

// Field positions inside the output frame control register.
`define OFC_UNIT_ID_BIT 14
`define OFC_SUPPLY_SEL_HI 13
`define OFC_SUPPLY_SEL_LO 12
`define OFC_INPUT_SEL_HI 11
`define OFC_INPUT_SEL_LO 10
`define OFC_SPAN_BIT 8
`define OFC_PARITY_BIT 3
`define OFC_SOURCE_HI 2
`define OFC_SOURCE_LO 0

// Reset values of the fields.
`define OFC_UNIT_ID_RST 1'b0
`define OFC_SUPPLY_SEL_RST 2'h0
`define OFC_INPUT_SEL_RST 2'h0
`define OFC_SPAN_RST 1'b0
`define OFC_PARITY_RST 1'b0
`define OFC_SOURCE_RST 3'h0

// Test pattern words.
`define PAT_ZEROS 16'h0000
`define PAT_ONES 16'hffff
`define PAT_SINGLE 16'h5555
`define PAT_PAIRS 16'h3333

// Frame geometry.
`define CONV_BITS 6'h10
`define ID_BITS 6'h04
`define SPAN_BITS 6'h04
`define FRAME_BITS 6'h20

`endif

// file: src/frame_skid_buffer.v
`default_nettype none

// Two-entry buffer: an output stage plus a skid stage, all outputs flopped.
module frame_skid_buffer #(
    parameter WIDTH = 40
) (
    input wire sys_clk_in,
    input wire clr_b_in,
    input wire in_valid_in,
    output reg in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output reg out_valid_out,
    input wire out_ready_in,
    output reg [WIDTH-1:0] out_data_out
);

    reg skid_valid_ff;
    reg [WIDTH-1:0] skid_data_ff;
    wire take_in;
    wire give_out;

    assign take_in = in_valid_in & in_ready_out;
    assign give_out = out_valid_out & out_ready_in;

    // The skid stage catches a word arriving while the output stalls.
    always @(posedge sys_clk_in) begin
        if (!clr_b_in) begin
            out_valid_out <= 1'b0;
            skid_valid_ff <= 1'b0;
            in_ready_out <= 1'b1;
            out_data_out <= {WIDTH{1'b0}};
            skid_data_ff <= {WIDTH{1'b0}};
        end else begin
            if (!out_valid_out || give_out) begin
                if (skid_valid_ff) begin
                    out_data_out <= skid_data_ff;
                    out_valid_out <= 1'b1;
                    skid_valid_ff <= take_in;
                    skid_data_ff <= in_data_in;
                end else begin
                    out_data_out <= in_data_in;
                    out_valid_out <= take_in;
                end
            end else if (take_in) begin
                skid_valid_ff <= 1'b1;
                skid_data_ff <= in_data_in;
            end
            in_ready_out <= !(skid_valid_ff || (out_valid_out && !out_ready_in
                && take_in)) || (skid_valid_ff && give_out && !take_in);
        end
    end

endmodule // frame_skid_buffer

`default_nettype wire

// file: src/adc_output_frame_composer.v
// Operation
// [R1] Unit id field set: four-bit unit id joins the frame, else omitted.
// [R2] Supply alert select: 00 none, 01 high, 10 low, 11 both flags.
// [R3] Input alert select: 00 none, 01 high, 10 low, 11 both flags.
// [R4] Span field set: four-bit span code joins the frame, else omitted.
// [R5] Parity on appends two bits at the frame end: result, then frame.
// [R6] Result parity is even parity over the conversion word alone.
// [R7] Frame parity is even parity over word and every included field.
// [R8] Result parity bit is not an input of the frame parity.
// [R9] Parity lengthens the frame by exactly two bits; host reads them.
// [R10] Word source: 0xx result, 100 zeros, 101 ones, 110 0101, 111 0011.
// [R11] Reserved control bits read zero and ignore writes.
// [R12] Application reset clears fields; power-on reset also clears parity.
// [R13] Frame carries the protocol select chosen for the serial lines.
// [R14] Fixed order: word, id, supply, input, span, parity last.
`include "frame_composer_regs.vh"
`default_nettype none

module adc_output_frame_composer (
    input wire sys_clk_in,
    input wire rst_b_in,
    input wire por_b_in,
    input wire reg_wr_in,
    input wire reg_rd_in,
    input wire [7:0] reg_addr_in,
    input wire [3:0] reg_be_in,
    input wire [31:0] reg_wdata_in,
    output reg [31:0] reg_rdata_out,
    output reg reg_rvalid_out,
    input wire conv_valid_in,
    output wire conv_ready_out,
    input wire [15:0] conv_data_in,
    input wire [3:0] unit_id_in,
    input wire [3:0] span_code_in,
    input wire supply_alert_hi_in,
    input wire supply_alert_lo_in,
    input wire input_alert_hi_in,
    input wire input_alert_lo_in,
    input wire [1:0] output_protocol_select_in,
    output wire frame_valid_out,
    input wire frame_ready_in,
    output wire [31:0] frame_data_out,
    output wire [5:0] frame_len_out,
    output wire [1:0] frame_proto_out
);

    reg add_unit_id_field_ff;
    reg [1:0] supply_alert_select_ff;
    reg [1:0] input_alert_select_ff;
    reg add_span_code_field_ff;
    reg parity_append_on_ff;
    reg [2:0] output_word_source_ff;
    reg [31:0] wmask;
    reg [31:0] nxt_ctl;
    reg [31:0] ctl_view;
    reg [15:0] word;
    reg [31:0] acc;
    reg [5:0] len;
    reg result_par;
    reg frame_par;
    reg [31:0] aligned;
    wire hit;
    wire clr_b;
    wire [39:0] buf_out;

    assign hit = (reg_addr_in == `OFC_OFFSET);
    assign clr_b = rst_b_in & por_b_in;

    // Byte enables and the writable mask form the next control value.
    always @* begin
        wmask = {{8{reg_be_in[3]}}, {8{reg_be_in[2]}},
            {8{reg_be_in[1]}}, {8{reg_be_in[0]}}} & `OFC_WRITE_MASK; // R11
        ctl_view = `OFC_RESET;
        ctl_view[`OFC_UNIT_ID_BIT] = add_unit_id_field_ff;
        ctl_view[`OFC_SUPPLY_SEL_HI:`OFC_SUPPLY_SEL_LO] =
            supply_alert_select_ff;
        ctl_view[`OFC_INPUT_SEL_HI:`OFC_INPUT_SEL_LO] = input_alert_select_ff;
        ctl_view[`OFC_SPAN_BIT] = add_span_code_field_ff;
        ctl_view[`OFC_PARITY_BIT] = parity_append_on_ff;
        ctl_view[`OFC_SOURCE_HI:`OFC_SOURCE_LO] = output_word_source_ff;
        nxt_ctl = (ctl_view & ~wmask) | (reg_wdata_in & wmask);
    end

    // Application reset clears the fields but leaves the parity bit alone.
    always @(posedge sys_clk_in) begin
        if (!clr_b) begin
            add_unit_id_field_ff <= `OFC_UNIT_ID_RST; // R12
            supply_alert_select_ff <= `OFC_SUPPLY_SEL_RST;
            input_alert_select_ff <= `OFC_INPUT_SEL_RST;
            add_span_code_field_ff <= `OFC_SPAN_RST;
            output_word_source_ff <= `OFC_SOURCE_RST;
        end else if (reg_wr_in && hit) begin
            add_unit_id_field_ff <= nxt_ctl[`OFC_UNIT_ID_BIT];
            supply_alert_select_ff <=
                nxt_ctl[`OFC_SUPPLY_SEL_HI:`OFC_SUPPLY_SEL_LO];
            input_alert_select_ff <=
                nxt_ctl[`OFC_INPUT_SEL_HI:`OFC_INPUT_SEL_LO];
            add_span_code_field_ff <= nxt_ctl[`OFC_SPAN_BIT];
            output_word_source_ff <= nxt_ctl[`OFC_SOURCE_HI:`OFC_SOURCE_LO];
        end
    end

    // Only a power-on reset clears the parity enable.
    always @(posedge sys_clk_in) begin
        if (!por_b_in) begin
            parity_append_on_ff <= `OFC_PARITY_RST; // R12
        end else if (reg_wr_in && hit) begin
            parity_append_on_ff <= nxt_ctl[`OFC_PARITY_BIT];
        end
    end

    // Reads answer one cycle later; unmapped addresses read zero.
    always @(posedge sys_clk_in) begin
        if (!clr_b) begin
            reg_rdata_out <= 32'h0000_0000;
            reg_rvalid_out <= 1'b0;
        end else begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in && hit) begin
                reg_rdata_out <= ctl_view; // R11
            end else begin
                reg_rdata_out <= 32'h0000_0000;
            end
        end
    end

    // Choose the word: live result or one of the test patterns.
    always @* begin
        case (output_word_source_ff) // R10
            3'h4: word = `PAT_ZEROS;
            3'h5: word = `PAT_ONES;
            3'h6: word = `PAT_SINGLE;
            3'h7: word = `PAT_PAIRS;
            default: word = conv_data_in;
        endcase
    end

    // Append enabled fields in fixed order, parity bits last.
    always @* begin
        acc = {16'h0000, word}; // R14
        len = `CONV_BITS;
        if (add_unit_id_field_ff) begin
            acc = {acc[27:0], unit_id_in}; // R1
            len = len + `ID_BITS;
        end
        if (supply_alert_select_ff[0]) begin
            acc = {acc[30:0], supply_alert_hi_in}; // R2
            len = len + 6'h01;
        end
        if (supply_alert_select_ff[1]) begin
            acc = {acc[30:0], supply_alert_lo_in}; // R2
            len = len + 6'h01;
        end
        if (input_alert_select_ff[0]) begin
            acc = {acc[30:0], input_alert_hi_in}; // R3
            len = len + 6'h01;
        end
        if (input_alert_select_ff[1]) begin
            acc = {acc[30:0], input_alert_lo_in}; // R3
            len = len + 6'h01;
        end
        if (add_span_code_field_ff) begin
            acc = {acc[27:0], span_code_in}; // R4
            len = len + `SPAN_BITS;
        end
        result_par = ^word; // R6
        frame_par = ^acc; // R7 R8
        if (parity_append_on_ff) begin
            acc = {acc[29:0], result_par, frame_par}; // R5
            len = len + 6'h02; // R9
        end
        aligned = acc << (`FRAME_BITS - len);
    end

    // The buffer holds frames so a stalled reader loses none.
    frame_skid_buffer #(
        .WIDTH(40)
    ) u_buffer (
        .sys_clk_in(sys_clk_in),
        .clr_b_in(clr_b),
        .in_valid_in(conv_valid_in),
        .in_ready_out(conv_ready_out),
        .in_data_in({output_protocol_select_in, len, aligned}), // R13
        .out_valid_out(frame_valid_out),
        .out_ready_in(frame_ready_in),
        .out_data_out(buf_out)
    );

    assign frame_data_out = buf_out[31:0];
    assign frame_len_out = buf_out[37:32];
    assign frame_proto_out = buf_out[39:38];

endmodule // adc_output_frame_composer

`default_nettype wire

// file: testbench/frame_composer_monitor.sv
`default_nettype none
// Watches the register port and the frame stream of the composer.
module frame_composer_monitor (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic por_b_in,
    input wire logic reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic reg_rvalid_out,
    input wire logic conv_valid_in,
    input wire logic conv_ready_out,
    input wire logic [1:0] output_protocol_select_in,
    input wire logic frame_valid_out,
    input wire logic frame_ready_in,
    input wire logic [31:0] frame_data_out,
    input wire logic [5:0] frame_len_out,
    input wire logic [1:0] frame_proto_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // All checks use the system clock and rest while either reset is low.
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in || !por_b_in);
    wire take = conv_valid_in && conv_ready_out;
    // Register port, then frame stream.
    a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read strobe got no answer");
    a_rdata_idle: assert property (!reg_rvalid_out |-> reg_rdata_out == 0)
        else $error("read data not zero while idle");
    a_reserved_zero: assert property (reg_rvalid_out |->
        (reg_rdata_out & 32'hffff_82f0) == 0) else $error("reserved bit set");
    a_tail_zero: assert property (frame_valid_out |->
        (frame_data_out << frame_len_out) == 0) else $error("bits past end");
    a_len_range: assert property (frame_valid_out |->
        frame_len_out >= 6'h10 && frame_len_out <= 6'h1e)
        else $error("frame length out of range");
    a_frame_hold: assert property (frame_valid_out && !frame_ready_in |=>
        frame_valid_out && $stable(frame_data_out) && $stable(frame_len_out))
        else $error("frame changed while stalled");
    a_word_answer: assert property (take |=> frame_valid_out)
        else $error("taken word gave no frame");
    a_proto_carry: assert property (take && !frame_valid_out |=>
        frame_proto_out == $past(output_protocol_select_in))
        else $error("protocol code not carried");
endmodule // frame_composer_monitor
`default_nettype wire

// file: testbench/frame_reader_model.sv
`default_nettype none
// Host reader that takes whole frames, slowly when asked to stall.
module frame_reader_model (
    input wire logic clk_in,
    input wire logic stall_in,
    input wire logic valid_in,
    input wire logic [31:0] data_in,
    input wire logic [5:0] len_in,
    output logic ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] tick_ff = 3'h0;
    logic [37:0] q[$];
    // Ready one cycle in eight while stalled, every cycle otherwise.
    assign ready_out = !stall_in || tick_ff == 3'h0;
    // Keeps each frame with its length so the read is sized to it.
    always @(posedge clk_in) begin
        tick_ff <= tick_ff + 3'h1;
        if (valid_in && ready_out) q.push_back({len_in, data_in});
    end
endmodule // frame_reader_model
`default_nettype wire

// file: testbench/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic rst_b_in = 1'b0, por_b_in = 1'b0, rd = 1'b0, wr = 1'b0;
    logic cv = 1'b0, stall = 1'b0, rvalid, cready, fvalid, fready;
    logic [7:0] addr = 8'h10;
    logic [31:0] wdata = 32'h0, rdata, fdata, cfg;
    logic [15:0] word = 16'h0;
    logic [3:0] uid = 4'h0, span = 4'h0;
    logic [3:0] be = 4'hf;
    logic [1:0] proto = 2'h0;
    logic [5:0] flen;
    logic [37:0] exp_q[$];
    logic [31:0] cfgs[17] = '{32'h4000, 32'h1000, 32'h2000, 32'h3000,
        32'h0400, 32'h0800, 32'h0c00, 32'h0100, 32'h0008, 32'h0004,
        32'h0005, 32'h0006, 32'h0007, 32'h7d0b, 32'h7d0f, 32'h0003,
        32'h0502};
    int failures = 0, checks_done = 0;
    wire [3:0] alerts = uid ^ {span[0], span[3:1]};
    // The composer and the host reader on its frame side.
    adc_output_frame_composer u_dut (.sys_clk_in(sys_clk_in),
        .rst_b_in(rst_b_in), .por_b_in(por_b_in), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_addr_in(addr), .reg_be_in(be),
        .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .conv_valid_in(cv), .conv_ready_out(cready), .conv_data_in(word),
        .unit_id_in(uid), .span_code_in(span),
        .supply_alert_hi_in(alerts[3]), .supply_alert_lo_in(alerts[2]),
        .input_alert_hi_in(alerts[1]), .input_alert_lo_in(alerts[0]),
        .output_protocol_select_in(proto), .frame_valid_out(fvalid),
        .frame_ready_in(fready), .frame_data_out(fdata),
        .frame_len_out(flen), .frame_proto_out());
    frame_reader_model u_host (.clk_in(sys_clk_in), .stall_in(stall),
        .valid_in(fvalid), .data_in(fdata), .len_in(flen),
        .ready_out(fready));
    // Free-running 125 MHz clock.
    always #4 sys_clk_in = ~sys_clk_in;
    task automatic chk(input string n, input logic [37:0] e, g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(input logic [31:0] d);
        @(negedge sys_clk_in);
        wr = 1'b1;
        wdata = d;
        @(negedge sys_clk_in);
        wr = 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(negedge sys_clk_in);
        rd = 1'b1;
        addr = a;
        @(negedge sys_clk_in);
        rd = 1'b0;
        addr = 8'h10;
        chk("read", {6'h1, e}, {5'h0, rvalid, rdata});
    endtask
    // Builds the expected left-aligned frame and its length.
    function automatic logic [37:0] frame_of(input logic [15:0] w);
        logic [31:0] f;
        int n;
        logic fp;
        logic [3:0] al;
        // The alert wire settles only after this call, so rebuild it here.
        al = uid ^ {span[0], span[3:1]};
        f = 32'h0;
        n = 16;
        if (cfg[2]) w = cfg[1] ? (cfg[0] ? 16'h3333 : 16'h5555)
            : {16{cfg[0]}};
        f[31:16] = w;
        if (cfg[14]) begin
            f[31-n-:4] = uid;
            n += 4;
        end
        for (int k = 3; k >= 0; k--) begin
            if (cfg[10 + (k ^ 1)]) begin
                f[31-n] = al[k];
                n++;
            end
        end
        if (cfg[8]) begin
            f[31-n-:4] = span;
            n += 4;
        end
        fp = ^f;
        if (cfg[3]) begin
            f[31-n] = ^w;
            f[30-n] = fp;
            n += 2;
        end
        return {n[5:0], f};
    endfunction
    task automatic send(input logic [15:0] w);
        cv = 1'b1;
        word = w;
        exp_q.push_back(frame_of(w));
        for (int t = 0; t < 50 && !cready; t++) @(negedge sys_clk_in);
        @(negedge sys_clk_in);
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    // Register checks, every frame option under a stalling reader, resets.
    initial begin
        repeat (10) @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        por_b_in = 1'b1;
        rd_reg(8'h10, 32'h0);
        wr_reg(32'hffff_ffff);
        rd_reg(8'h10, 32'h0000_7d0f);
        // A write with only the second byte lane enabled clears that lane.
        be = 4'h2;
        wr_reg(32'h0000_0000);
        be = 4'hf;
        rd_reg(8'h10, 32'h0000_000f);
        rd_reg(8'h14, 32'h0);
        stall = 1'b1;
        foreach (cfgs[i]) begin
            cfg = cfgs[i];
            wr_reg(cfgs[i]);
            for (int j = 0; j < 3; j++) begin
                uid = 4'(i);
                span = 4'(j - i);
                proto = 2'(j);
                send(16'(16'h9e37 * (3 * i + j + 1)));
            end
            cv = 1'b0;
        end
        stall = 1'b0;
        for (int t = 0; t < 100 && u_host.q.size() < exp_q.size(); t++)
            @(negedge sys_clk_in);
        chk("count", 38'(exp_q.size()), 38'(u_host.q.size()));
        foreach (exp_q[k]) begin
            chk("frame", exp_q[k], u_host.q[k]);
        end
        wr_reg(32'h0000_7d0f);
        rst_b_in = 1'b0;
        @(negedge sys_clk_in);
        rst_b_in = 1'b1;
        rd_reg(8'h10, 32'h0000_0008);
        por_b_in = 1'b0;
        @(negedge sys_clk_in);
        por_b_in = 1'b1;
        rd_reg(8'h10, 32'h0);
        end_of_test();
    end
    // Cuts a hang short well after the tests should have ended.
    initial begin
        #50us;
        failures++;
        end_of_test();
    end
endmodule // tb_top
bind adc_output_frame_composer frame_composer_monitor u_mon (
    .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .por_b_in(por_b_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out), .conv_valid_in(conv_valid_in),
    .conv_ready_out(conv_ready_out),
    .output_protocol_select_in(output_protocol_select_in),
    .frame_valid_out(frame_valid_out), .frame_ready_in(frame_ready_in),
    .frame_data_out(frame_data_out), .frame_len_out(frame_len_out),
    .frame_proto_out(frame_proto_out));
`default_nettype wire
